// ### miwc_core_model.sv
// miwc_core_model: behavioural core sequencer facing the controller.
// assumes the bench asks for returns; instructions take 4 clocks each.
module miwc_core_model
    import miwc_pkg::*;
(
    // clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          nrst_in,
    // bench requests, bit0 interrupt exit, bit1 plain return
    input  wire logic [1:0]                    ret_req_in,
    // to controller
    output logic                               instr_boundary_out,
    output logic      [miwc_pkg::MIWC_PC_W-1:0] core_pc_out,
    output logic                               exit_irq_out,
    output logic                               exit_plain_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_q;
    logic [1:0] pend_q;

    // boundary once per instruction cycle
    assign instr_boundary_out = (phase_q == 2'h3);
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            phase_q        <= 2'h0;
            pend_q         <= 2'h0;
            core_pc_out    <= 14'h0100;
            exit_irq_out   <= 1'b0;
            exit_plain_out <= 1'b0;
        end else begin
            phase_q        <= phase_q + 2'h1;
            exit_irq_out   <= instr_boundary_out && pend_q[0];
            exit_plain_out <= instr_boundary_out && pend_q[1];
            if (instr_boundary_out) begin
                core_pc_out <= core_pc_out + 14'h0001;
                pend_q      <= ret_req_in;
            end else begin
                pend_q <= pend_q | ret_req_in;
            end
        end
    end
endmodule

// ### miwc_irq_asserts.sv
// miwc_irq_asserts: port-level checks on the interrupt controller.
// assumes binding into miwc_irq_ctrl; sees its ports only.
module miwc_irq_asserts
    import miwc_pkg::*;
#(
    parameter logic [1:0] FOSC_OPT  = miwc_pkg::MIWC_FOSC_8M,
    parameter logic       SLOW_XTAL = 1'b0
) (
    // clock and reset
    input wire logic       ref_clk_in,
    input wire logic       nrst_in,
    // bus
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    // core side
    input wire logic       instr_boundary_in,
    input wire logic       interrupt_exit_instr_in,
    input wire logic       subroutine_exit_plain_in,
    input wire logic       low_power_in,
    input wire logic       vector_call_out,
    input wire logic [2:0] vector_num_out,
    input wire logic       return_valid_out,
    input wire logic       wakeup_out,
    input wire logic       global_irq_enable_out,
    // options
    input wire logic [1:0] fast_osc_sel_out,
    input wire logic       slow_crystal_osc_sel_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing");
    a_call_gated: assert property (vector_call_out |->
        $past(global_irq_enable_out) && $past(instr_boundary_in)) else $error("call not gated");
    a_call_clears_gie: assert property (vector_call_out |-> !global_irq_enable_out)
        else $error("gie kept on call");
    a_one_at_time: assert property (vector_call_out |=> !vector_call_out [*7])
        else $error("calls too close");
    a_vec_legal: assert property (vector_call_out |-> vector_num_out < MIWC_NUM_VEC)
        else $error("bad vector");
    a_exit_sets_gie: assert property (return_valid_out && $past(interrupt_exit_instr_in)
        |-> global_irq_enable_out) else $error("exit left gie low");
    a_plain_keeps_gie: assert property (return_valid_out && $past(subroutine_exit_plain_in)
        |-> $stable(global_irq_enable_out)) else $error("plain return moved gie");
    a_wake_lowpower: assert property (wakeup_out |-> $past(low_power_in))
        else $error("wake outside low power");
    a_opts_fixed: assert property ($past(nrst_in) |-> fast_osc_sel_out == FOSC_OPT &&
        slow_crystal_osc_sel_out == SLOW_XTAL) else $error("options moved");
endmodule

bind miwc_irq_ctrl miwc_irq_asserts #(.FOSC_OPT(FOSC_OPT), .SLOW_XTAL(SLOW_XTAL)) u_chk (
    .ref_clk_in, .nrst_in, .avs_read, .avs_write, .avs_waitrequest, .instr_boundary_in,
    .interrupt_exit_instr_in, .subroutine_exit_plain_in, .low_power_in, .vector_call_out,
    .vector_num_out, .return_valid_out, .wakeup_out, .global_irq_enable_out,
    .fast_osc_sel_out, .slow_crystal_osc_sel_out);

// ### miwc_irq_ctrl.sv
// miwc_irq_ctrl: interrupt flags, enables, vectoring and wake-up for the core.
// assumes the core's sequencer gives a boundary strobe, return strobes and the
// program counter; everything runs on ref_clk_in, synchronous reset.
//
// The Avalon-MM slave port and the address map were left to the implementer.
module miwc_irq_ctrl
    import miwc_pkg::*;
#(
    parameter int                    CALL_CYCLES = 8, // two instruction cycles
    parameter logic [1:0]            FOSC_OPT    = miwc_pkg::MIWC_FOSC_8M,
    parameter logic                  SLOW_XTAL   = 1'b0
) (
    // clock and reset
    input  wire logic                              ref_clk_in,
    input  wire logic                              nrst_in,
    // avalon-mm slave
    input  wire logic [3:0]                        avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [31:0]                       avs_writedata,
    output logic      [31:0]                       avs_readdata,
    output logic                                   avs_waitrequest,
    // event sources, one-cycle pulses
    input  wire logic                              converter_done_in,
    input  wire logic [1:0]                        compact_timer_zero_in,
    input  wire logic [1:0]                        periodic_timer_zero_in,
    input  wire logic [1:0]                        periodic_timer_one_in,
    // core sequencer
    input  wire logic                              instr_boundary_in,
    input  wire logic [miwc_pkg::MIWC_PC_W-1:0]    core_pc_in,
    input  wire logic                              interrupt_exit_instr_in,
    input  wire logic                              subroutine_exit_plain_in,
    input  wire logic                              low_power_in,
    // to core
    output logic                                   vector_call_out,
    output logic      [2:0]                        vector_num_out,
    output logic                                   return_valid_out,
    output logic      [miwc_pkg::MIWC_PC_W-1:0]    return_pc_out,
    output logic                                   wakeup_out,
    output logic                                   global_irq_enable_out,
    // fixed options
    output logic      [1:0]                        fast_osc_sel_out,
    output logic                                   slow_crystal_osc_sel_out
);
    import miwc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [MIWC_CTL_W-1:0] ctrl_q;
    logic [MIWC_FLG_W-1:0] flags_q, flags_d;
    logic [MIWC_FLG_W-1:0] flags_prev_q;
    miwc_state_e           state_q, state_d;
    logic [3:0]            cnt_q, cnt_d;

    logic [2:0]            vec_q;
    logic                  call_q, rv_q, wake_q, wait_q;
    logic [31:0]           rdata_q;

    logic [MIWC_PC_W-1:0]  rpc_q;
    logic [1:0]            fosc_q;
    logic                  xtal_q;

    wire [$clog2(MIWC_STACK_DEPTH):0] stk_level;
    wire [MIWC_PC_W-1:0]              stk_top;
    wire                              stk_full;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire bus_req  = (avs_read || avs_write) && wait_q;
    // writes land on the answering edge
    wire bus_acc  = (avs_read || avs_write) && !wait_q;
    wire wr_ctrl  = bus_acc && avs_write && (avs_address == MIWC_REG_CTRL);
    wire wr_flags = bus_acc && avs_write && (avs_address == MIWC_REG_FLAGS);
    wire wr_fset  = bus_acc && avs_write && (avs_address == MIWC_REG_FSET);

    // ----------------------------------------------------------------
    // request evaluation
    // ----------------------------------------------------------------
    wire gie = ctrl_q[MIWC_CTL_GIE];
    wire [5:0] pend;
    assign pend[MIWC_VEC_CTA] = flags_q[MIWC_FLG_CTA] && ctrl_q[MIWC_CTL_CTA];
    assign pend[MIWC_VEC_CTP] = flags_q[MIWC_FLG_CTP] && ctrl_q[MIWC_CTL_CTP];
    assign pend[MIWC_VEC_P0A] = flags_q[MIWC_FLG_P0A] && ctrl_q[MIWC_CTL_P0A];
    assign pend[MIWC_VEC_P0P] = flags_q[MIWC_FLG_P0P] && ctrl_q[MIWC_CTL_P0P];
    assign pend[MIWC_VEC_ADC] = flags_q[MIWC_FLG_ADF] && ctrl_q[MIWC_CTL_ADE];

    // member enables plus the shared enable gate the shared vector
    wire p1_req = (flags_q[MIWC_FLG_P1A] && ctrl_q[MIWC_CTL_P1A])
               || (flags_q[MIWC_FLG_P1P] && ctrl_q[MIWC_CTL_P1P]);
    assign pend[MIWC_VEC_MF] = flags_q[MIWC_FLG_MFF] && ctrl_q[MIWC_CTL_MFE] && p1_req;

    function automatic logic [2:0] pick(input logic [5:0] p);
        logic [2:0] v;
        v = MIWC_VEC_NONE;
        for (int i = 5; i >= 0; i--) begin
            if (p[i]) begin
                v = 3'(i);
            end
        end
        return v;
    endfunction

    wire [2:0] win_vec = pick(pend);
    wire take = (state_q == MIWC_ST_IDLE) && instr_boundary_in && gie
             && !stk_full && (win_vec != MIWC_VEC_NONE);
    wire ret_any = interrupt_exit_instr_in || subroutine_exit_plain_in;
    wire start_ret = (state_q == MIWC_ST_IDLE) && !take && ret_any;

    wire cnt_last  = (cnt_q == 4'(CALL_CYCLES - 1));
    wire call_done = (state_q == MIWC_ST_CALL) && cnt_last;
    wire ret_done  = (state_q == MIWC_ST_RET) && cnt_last;

    // ----------------------------------------------------------------
    // flags: set wins over any clear in the same cycle
    // ----------------------------------------------------------------
    logic [MIWC_FLG_W-1:0] set_v, clr_v;
    always_comb begin
        set_v = '0;
        clr_v = '0;

        set_v[MIWC_FLG_ADF] = converter_done_in;
        set_v[MIWC_FLG_CTA] = compact_timer_zero_in[0];
        set_v[MIWC_FLG_CTP] = compact_timer_zero_in[1];
        set_v[MIWC_FLG_P0A] = periodic_timer_zero_in[0];
        set_v[MIWC_FLG_P0P] = periodic_timer_zero_in[1];
        set_v[MIWC_FLG_P1A] = periodic_timer_one_in[0];
        set_v[MIWC_FLG_P1P] = periodic_timer_one_in[1];
        set_v[MIWC_FLG_MFF] = |periodic_timer_one_in;

        if (wr_fset) begin
            set_v = set_v | avs_writedata[MIWC_FLG_W-1:0];
        end
        if (wr_flags) begin
            clr_v = avs_writedata[MIWC_FLG_W-1:0];
        end
        if (take) begin
            case (win_vec)
                MIWC_VEC_CTA: clr_v[MIWC_FLG_CTA] = 1'b1;
                MIWC_VEC_CTP: clr_v[MIWC_FLG_CTP] = 1'b1;
                MIWC_VEC_P0A: clr_v[MIWC_FLG_P0A] = 1'b1;
                MIWC_VEC_P0P: clr_v[MIWC_FLG_P0P] = 1'b1;
                MIWC_VEC_ADC: clr_v[MIWC_FLG_ADF] = 1'b1;
                MIWC_VEC_MF:  clr_v[MIWC_FLG_MFF] = 1'b1;
                default: clr_v = clr_v;
            endcase
        end

        flags_d = (flags_q & ~clr_v) | set_v;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 1'b1;
        case (state_q)
            MIWC_ST_IDLE: begin
                cnt_d = '0;
                if (take) begin
                    state_d = MIWC_ST_CALL;
                end else if (start_ret) begin
                    state_d = MIWC_ST_RET;
                end
            end
            MIWC_ST_CALL: begin
                if (call_done) begin
                    state_d = MIWC_ST_IDLE;
                end
            end
            MIWC_ST_RET: begin
                if (ret_done) begin
                    state_d = MIWC_ST_IDLE;
                end
            end
            default: begin
                state_d = MIWC_ST_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    // only the pc is saved; accumulator and status are left to software
    miwc_pc_stack #(
        .DEPTH (MIWC_STACK_DEPTH),
        .PC_W  (MIWC_PC_W)
    ) u_stack (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .push_in    (take),
        .pop_in     (start_ret),
        .push_pc_in (core_pc_in),
        .top_pc_out (stk_top),
        .level_out  (stk_level),
        .full_out   (stk_full)
    );

    // ----------------------------------------------------------------
    // enables
    // ----------------------------------------------------------------
    logic [MIWC_CTL_W-1:0] ctrl_d;
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = avs_writedata[MIWC_CTL_W-1:0];
        end

        if (take) begin
            ctrl_d[MIWC_CTL_GIE] = 1'b0;
        end else if (start_ret && interrupt_exit_instr_in) begin
            ctrl_d[MIWC_CTL_GIE] = 1'b1;
        end
        // plain return leaves the enable as it is
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            ctrl_q       <= MIWC_CTRL_RST;
            flags_q      <= MIWC_FLAGS_RST;
            flags_prev_q <= MIWC_FLAGS_RST;
            state_q      <= MIWC_ST_IDLE;
            cnt_q        <= '0;
        end else begin
            ctrl_q       <= ctrl_d;
            flags_q      <= flags_d;
            flags_prev_q <= flags_q;
            state_q      <= state_d;
            cnt_q        <= cnt_d;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            call_q <= 1'b0;
            vec_q  <= MIWC_VEC_NONE;
            rv_q   <= 1'b0;
            rpc_q  <= '0;
            wake_q <= 1'b0;
        end else begin
            call_q <= take;
            vec_q  <= take ? win_vec : vec_q;
            rv_q   <= start_ret;
            rpc_q  <= start_ret ? stk_top : rpc_q;

            // rising flag wakes regardless of enables
            wake_q <= low_power_in && |(flags_q & ~flags_prev_q);
        end
    end

    // options reload from the parameters on every clock out of reset and are never written by software
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            fosc_q <= MIWC_FOSC_8M;
            xtal_q <= 1'b0;
        end else begin
            fosc_q <= FOSC_OPT;
            xtal_q <= SLOW_XTAL;
        end
    end

    // ----------------------------------------------------------------
    // bus answer: one wait cycle, then data
    // ----------------------------------------------------------------
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        case (avs_address)
            MIWC_REG_CTRL:   rmux[MIWC_CTL_W-1:0] = ctrl_q;
            MIWC_REG_FLAGS:  rmux[MIWC_FLG_W-1:0] = flags_q;
            MIWC_REG_STATUS: rmux[11:0] = {stk_level, stk_full, state_q, vec_q, wake_q};
            MIWC_REG_OPTION: rmux[2:0]  = {xtal_q, fosc_q};
            default:         rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q  <= !bus_req;
            rdata_q <= (bus_req && avs_read) ? rmux : rdata_q;
        end
    end

    assign avs_readdata          = rdata_q;
    assign avs_waitrequest       = wait_q;

    assign vector_call_out       = call_q;
    assign vector_num_out        = vec_q;
    assign return_valid_out      = rv_q;
    assign return_pc_out         = rpc_q;
    assign wakeup_out            = wake_q;
    assign global_irq_enable_out = ctrl_q[MIWC_CTL_GIE];

    assign fast_osc_sel_out      = fosc_q;
    assign slow_crystal_osc_sel_out = xtal_q;
endmodule

// ### miwc_pc_stack.sv
// miwc_pc_stack: program-counter return stack of flip-flops.
// assumes push and pop never arrive together and pop only when not empty.
module miwc_pc_stack #(
    parameter int DEPTH = 8,
    parameter int PC_W  = 14
) (
    // clock and reset
    input  wire logic                      ref_clk_in,
    input  wire logic                      nrst_in,
    // push and pop
    input  wire logic                      push_in,
    input  wire logic                      pop_in,
    input  wire logic [PC_W-1:0]           push_pc_in,
    // state
    output logic      [PC_W-1:0]           top_pc_out,
    output logic      [$clog2(DEPTH):0]    level_out,
    output logic                           full_out
);
    logic [PC_W-1:0]        mem_q [DEPTH];
    logic [$clog2(DEPTH):0] level_q;
    wire  [$clog2(DEPTH)-1:0] wr_idx  = level_q[$clog2(DEPTH)-1:0];
    wire  [$clog2(DEPTH)-1:0] top_idx = wr_idx - 1'b1;
    wire                      is_full = (level_q == ($clog2(DEPTH)+1)'(DEPTH));

    always_ff @(posedge ref_clk_in) begin
        if (push_in && !is_full) begin
            mem_q[wr_idx] <= push_pc_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            level_q <= '0;
        end else if (push_in && !is_full) begin
            level_q <= level_q + 1'b1;
        end else if (pop_in && level_q != '0) begin
            level_q <= level_q - 1'b1;
        end
    end

    assign top_pc_out = (level_q == '0) ? '0 : mem_q[top_idx];
    assign level_out  = level_q;
    assign full_out   = is_full;
endmodule

// ### miwc_pkg.sv
// miwc_pkg: register map, field positions, reset values and enumerations
// for the interrupt request, vectoring and wake-up block.
// assumes one 100 MHz system clock and a word-addressed Avalon-MM slave.
//
// Notes on behaviour
// - converter done sets its request flag.
// - converter vector needs global enable, own enable, stack not full, flag.
// - servicing converter clears its flag and the global enable.
// - shared flag sets whenever a second periodic timer flag sets; here only on a timer pulse, not on an FSET write.
// - shared service clears shared flag and global enable only; members stay.
// - each timer has compare A and compare P requests; timer zero own vectors.
// - second periodic timer also needs the shared enable.
// - servicing timer zero clears its taken flag and the global enable.
// - any request flag rising wakes from sleep or idle, enables ignored.
// - a set flag stays set until serviced or cleared by software.
// - interrupt entry pushes only the program counter.
// - interrupt exit returns and sets the global enable.
// - plain return returns and leaves the global enable untouched.
// - configuration options are fixed at programming, not software writable.
// - fast oscillator option selects 8, 12 or 16 MHz; software matches it.
// - option selects slow clock from internal oscillator or crystal.
package miwc_pkg;

    // ----------------------------------------------------------------
    // register word offsets (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [3:0] MIWC_REG_CTRL   = 4'h0; // enables
    localparam logic [3:0] MIWC_REG_FLAGS  = 4'h1; // request flags, w1 clears
    localparam logic [3:0] MIWC_REG_FSET   = 4'h2; // write 1 sets a flag
    localparam logic [3:0] MIWC_REG_STATUS = 4'h3; // vector, wake, stack depth
    localparam logic [3:0] MIWC_REG_OPTION = 4'h4; // programming-time options

    // ctrl bit positions
    localparam int MIWC_CTL_GIE  = 0;
    localparam int MIWC_CTL_ADE  = 1;
    localparam int MIWC_CTL_MFE  = 2;
    localparam int MIWC_CTL_CTA  = 3;
    localparam int MIWC_CTL_CTP  = 4;
    localparam int MIWC_CTL_P0A  = 5;
    localparam int MIWC_CTL_P0P  = 6;
    localparam int MIWC_CTL_P1A  = 7;
    localparam int MIWC_CTL_P1P  = 8;
    localparam int MIWC_CTL_W    = 9;

    // flag bit positions
    localparam int MIWC_FLG_ADF  = 0;
    localparam int MIWC_FLG_MFF  = 1;
    localparam int MIWC_FLG_CTA  = 2;
    localparam int MIWC_FLG_CTP  = 3;
    localparam int MIWC_FLG_P0A  = 4;
    localparam int MIWC_FLG_P0P  = 5;
    localparam int MIWC_FLG_P1A  = 6;
    localparam int MIWC_FLG_P1P  = 7;
    localparam int MIWC_FLG_W    = 8;

    localparam logic [MIWC_CTL_W-1:0] MIWC_CTRL_RST  = 9'h000;
    localparam logic [MIWC_FLG_W-1:0] MIWC_FLAGS_RST = 8'h00;

    localparam int             MIWC_STACK_DEPTH = 8;
    localparam int             MIWC_PC_W        = 14;
    localparam logic [2:0]     MIWC_NUM_VEC     = 3'h6;

    // vector numbers in priority order, lowest number wins
    typedef enum logic [2:0] {
        MIWC_VEC_CTA = 3'h0,
        MIWC_VEC_CTP = 3'h1,
        MIWC_VEC_P0A = 3'h2,
        MIWC_VEC_P0P = 3'h3,
        MIWC_VEC_ADC = 3'h4,
        MIWC_VEC_MF  = 3'h5,
        MIWC_VEC_NONE = 3'h7
    } miwc_vec_e;

    // fast oscillator option codes
    localparam logic [1:0] MIWC_FOSC_8M  = 2'h0;
    localparam logic [1:0] MIWC_FOSC_12M = 2'h1;
    localparam logic [1:0] MIWC_FOSC_16M = 2'h2;

    // control sequencer states
    typedef enum logic [2:0] {
        MIWC_ST_IDLE = 3'b001,
        MIWC_ST_CALL = 3'b010,
        MIWC_ST_RET  = 3'b100
    } miwc_state_e;

endpackage

// ### tb_mcu_interrupt_wakeup_ctrl.sv
// tb_mcu_interrupt_wakeup_ctrl: random and corner tests of the controller.
// assumes miwc_core_model as the core and the bench as bus master.
module tb_mcu_interrupt_wakeup_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import miwc_pkg::*;

    logic ref_clk_in, nrst_in, avs_read, avs_write, avs_waitrequest, low_power, boundary;
    logic exit_irq, exit_plain, vcall, rvalid, wake, gie, xsel, hit;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [6:0]  src_q;
    logic [1:0]  ret_req, fsel;
    logic [2:0]  vnum, v;
    logic [13:0] core_pc, rpc, pc_prev, pushed;
    logic [7:0]  fl;
    int          failures, compares, n;

    miwc_irq_ctrl #(.FOSC_OPT(MIWC_FOSC_12M), .SLOW_XTAL(1'b1)) uut (
        .ref_clk_in, .nrst_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest,
        .converter_done_in(src_q[0]), .compact_timer_zero_in(src_q[2:1]),
        .periodic_timer_zero_in(src_q[4:3]), .periodic_timer_one_in(src_q[6:5]),
        .instr_boundary_in(boundary), .core_pc_in(core_pc),
        .interrupt_exit_instr_in(exit_irq), .subroutine_exit_plain_in(exit_plain),
        .low_power_in(low_power), .vector_call_out(vcall), .vector_num_out(vnum),
        .return_valid_out(rvalid), .return_pc_out(rpc), .wakeup_out(wake),
        .global_irq_enable_out(gie), .fast_osc_sel_out(fsel), .slow_crystal_osc_sel_out(xsel));
    miwc_core_model core (.ref_clk_in, .nrst_in, .ret_req_in(ret_req),
        .instr_boundary_out(boundary), .core_pc_out(core_pc), .exit_irq_out(exit_irq),
        .exit_plain_out(exit_plain));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // pc the controller sampled at its taking edge
    always @(posedge ref_clk_in) begin
        pc_prev <= core_pc;
        if (vcall === 1'b1) pushed <= pc_prev;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk_in);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic clr();
        bus(1, MIWC_REG_FLAGS, 32'h0000_00ff);
    endtask
    task automatic pulse(input int j);
        src_q <= 7'(1 << j);
        @(posedge ref_clk_in);
        src_q <= 7'h00;
    endtask
    // k: 0 vector call, 1 return, 2 wake-up
    task automatic wait_ev(input int k);
        hit = 1'b0;
        repeat (60) begin
            @(posedge ref_clk_in);
            hit = (k == 0) ? vcall === 1'b1 : (k == 1) ? rvalid === 1'b1 : wake === 1'b1;
            if (hit) break;
        end
    endtask
    task automatic ret(input logic [1:0] kind);
        repeat (10) @(posedge ref_clk_in);
        ret_req <= kind;
        @(posedge ref_clk_in);
        ret_req <= 2'h0;
        wait_ev(1);
        check(hit, 1);
        check(rpc, pushed);
        check(gie, kind[0]);
    endtask
    function automatic logic [2:0] exp_vec(input logic [7:0] f);
        logic [2:0] r;
        r = (f[0]) ? 3'h4 : 3'h7;
        for (int i = 5; i >= 2; i--) if (f[i]) r = 3'(i - 2);
        return r;
    endfunction
    function automatic logic [31:0] exp_flag(input int j);
        logic [31:0] f;
        f = (j == 0) ? 32'h0000_0001 : 32'h0000_0001 << (j + 1);
        if (j >= 5) f[1] = 1'b1;
        return f;
    endfunction

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        n = $urandom(47376);
        {nrst_in, avs_read, avs_write, low_power, src_q, ret_req, avs_address, avs_writedata} = '0;
        repeat (12) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        @(posedge ref_clk_in);
        check(avs_waitrequest, 1);
        check(vnum, 7);
        check(gie, 0);
        for (int i = 0; i < 2; i++) begin
            bus(0, MIWC_REG_OPTION, 32'h0000_0000);
            check(rd, {29'h0, 1'b1, MIWC_FOSC_12M});
            bus(1, MIWC_REG_OPTION, 32'hffff_ffff);
        end
        bus(0, 4'hf, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            n = $urandom & 32'h0000_01ff;
            bus(1, MIWC_REG_CTRL, n);
            bus(0, MIWC_REG_CTRL, 32'h0000_0000);
            check(rd, n);
        end
        bus(1, MIWC_REG_CTRL, 32'h0000_0000);
        // each source under low power with every enable off
        low_power <= 1'b1;
        for (int j = 0; j < 7; j++) begin
            clr();
            pulse(j);
            wait_ev(2);
            check(hit, 1);
            bus(0, MIWC_REG_FLAGS, 32'h0000_0000);
            check(rd, exp_flag(j));
            pulse(j);
            wait_ev(2);
            check(hit, 0);
        end
        low_power <= 1'b0;
        // simultaneous pending requests
        for (int i = 0; i < 6; i++) begin
            fl = (i == 0) ? 8'h3d : 8'($urandom) & 8'h3d;
            if (fl == 8'h00) fl = 8'h01;
            v = exp_vec(fl);
            clr();
            bus(1, MIWC_REG_CTRL, 32'h0000_01fb);
            bus(1, MIWC_REG_FSET, {24'h0, fl});
            wait_ev(0);
            check(hit, 1);
            check(vnum, v);
            check(gie, 0);
            if (v == 3'h4) fl[0] = 1'b0;
            else fl[v + 2] = 1'b0;
            bus(0, MIWC_REG_FLAGS, 32'h0000_0000);
            check(rd, fl);
            clr();
            ret(i[0] ? 2'b01 : 2'b10);
        end
        // second periodic timer behind the shared enable
        clr();
        bus(1, MIWC_REG_CTRL, 32'h0000_0081);
        pulse(5);
        wait_ev(0);
        check(hit, 0);
        bus(1, MIWC_REG_CTRL, 32'h0000_0085);
        wait_ev(0);
        check(hit, 1);
        check(vnum, MIWC_VEC_MF);
        bus(0, MIWC_REG_FLAGS, 32'h0000_0000);
        check(rd, 32'h0000_0040);
        clr();
        ret(2'b01);
        results();
    end
    initial begin
        #100000;
        failures++;
        results();
    end
endmodule
